/* shared/pmc_pkg.sv */
package pmc_pkg;

  // ------------------------------------------------------------
  // power modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_POR,
    PMC_SHUTDOWN,
    PMC_SLEEP,
    PMC_ACTIVE
  } pmc_mode_type;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int PMC_CLK_HZ = 25000000;
  // long timeout in milliseconds, default of the programmable interval
  localparam int PMC_LONG_TO_MS = 1000;
  localparam int PMC_LONG_TO_CYCLES = PMC_CLK_HZ / 1000 * PMC_LONG_TO_MS;
  localparam int PMC_TO_WIDTH = 32;
  localparam int PMC_SYNC_WIDTH = 7;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic PMC_FLAG_RESET = 1'b0;

  // ------------------------------------------------------------
  // synchronised event inputs, bit positions
  // ------------------------------------------------------------
  localparam int PMC_IN_REF_OK = 0;
  localparam int PMC_IN_WAKE_N = 1;
  localparam int PMC_IN_WAKE_TONE = 2;
  localparam int PMC_IN_RESUME_UART = 3;
  localparam int PMC_IN_RESUME_TONE = 4;
  localparam int PMC_IN_THERMAL = 5;
  localparam int PMC_IN_FRAME = 6;

  // ------------------------------------------------------------
  // function enables per mode
  // ------------------------------------------------------------
  typedef struct packed {
    logic wake_detect;
    logic comparators;
    logic balancing;
    logic resume_detect;
    logic shutdown_detect;
    logic fault_tone;
    logic gpio_fault;
    logic nvm_crc;
    logic comms;
    logic adc_reads;
    logic spi_master;
    logic comm_timeout;
  } pmc_func_type;

  typedef struct packed {
    logic enter_sleep_cmd;
    logic enter_shutdown_cmd;
    logic reset_flag_clear_bit;
    logic long_timeout_enable;
    logic heartbeat_enable;
  } pmc_cmd_type;

  function automatic pmc_func_type pmc_gate(input pmc_mode_type m);
    pmc_func_type f;
    f = '0;
    f.wake_detect = (m != PMC_POR);
    f.comparators = (m == PMC_SLEEP) || (m == PMC_ACTIVE);
    f.balancing = f.comparators;
    f.resume_detect = f.comparators;
    f.shutdown_detect = f.comparators;
    f.fault_tone = f.comparators;
    f.gpio_fault = f.comparators;
    f.nvm_crc = f.comparators;
    f.comms = (m == PMC_ACTIVE);
    f.adc_reads = f.comms;
    f.spi_master = f.comms;
    f.comm_timeout = f.comms;
    return f;
  endfunction

endpackage

/* src/pmc_sync.sv */
`timescale 1ns/100ps
module pmc_sync
  import pmc_pkg::*;
#(
  parameter int WIDTH = PMC_SYNC_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage;

  if (WIDTH < 1) begin : g_bad_width
    $error("pmc_sync width must be positive");
  end

  // first stage is read only by the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
      sync_out <= '0;
    end else begin
      stage <= async_in;
      sync_out <= stage;
    end
  end
endmodule

/* src/power_mode_controller.sv */
`timescale 1ns/100ps
// Functional notes
// - device is always in exactly one of four modes
// - reference supply low keeps device in power-on reset, all held
// - supply valid moves reset to shutdown and sets reset flag
// - shutdown waits only for wake pulse or wake tone, then active
// - sleep runs comparators, balancing, detectors, fault tone, gpio, crc
// - comparators and fault tone enabled in active persist through sleep
// - resume signal in sleep enters active keeping settings
// - wake in sleep restores defaults then enters active
// - clearing the reset flag releases fault output, starts heartbeat
// - wake in active resets settings, forwards it, sets flag
// - resume in active is forwarded, nothing else changes
// - sleep command in active enters sleep
// - enabled long timeout with no frame enters shutdown
// - thermal trip or shutdown command enters shutdown
// - function enables follow the present mode
// - thermal trip aborts transactions at once, no fault signalled
// - shutdown is left only through wake, or to power-on reset on supply loss
module power_mode_controller
  import pmc_pkg::*;
#(
  parameter int LONG_TO_CYCLES = PMC_LONG_TO_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic always_on_reference,
  input wire logic wake_n,
  input wire logic wake_tone,
  input wire logic resume_uart,
  input wire logic resume_tone,
  input wire logic thermal_trip,
  input wire logic frame_valid,
  input wire pmc_cmd_type cmd,
  output pmc_mode_type mode,
  output pmc_func_type func_enable,
  output logic reset_occurred_flag,
  output logic fault_output_n,
  output logic heartbeat_run,
  output logic settings_reset,
  output logic wake_forward,
  output logic resume_forward,
  output logic abort_transactions,
  output logic circuits_held
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (LONG_TO_CYCLES < 1) begin : g_bad_long_to
    $error("long timeout count must be at least one");
  end
  // every event bit position must fall inside the synchroniser bus
  if (PMC_IN_FRAME >= PMC_SYNC_WIDTH) begin : g_bad_sync_map
    $error("synchroniser narrower than the event map");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // rising edge of a level against its copy from the previous cycle
  function automatic logic pmc_rise(
    input logic now_lvl,
    input logic last_lvl
  );
    return now_lvl & ~last_lvl;
  endfunction

  // ------------------------------------------------------------
  // reset release and input synchronisers
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  wire [PMC_SYNC_WIDTH-1:0] raw_in = {
    frame_valid, thermal_trip, resume_tone, resume_uart,
    wake_tone, ~wake_n, always_on_reference
  };
  wire [PMC_SYNC_WIDTH-1:0] sync_in;

  pmc_sync #(
    .WIDTH(PMC_SYNC_WIDTH)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  wire ref_ok = sync_in[PMC_IN_REF_OK];
  wire wake_low = sync_in[PMC_IN_WAKE_N];
  wire tone_lvl = sync_in[PMC_IN_WAKE_TONE];
  wire res_uart = sync_in[PMC_IN_RESUME_UART];
  wire res_tone = sync_in[PMC_IN_RESUME_TONE];
  wire thermal = sync_in[PMC_IN_THERMAL];
  wire frame = sync_in[PMC_IN_FRAME];

  // ------------------------------------------------------------
  // event detection
  // ------------------------------------------------------------
  logic wake_low_d;
  logic tone_d;
  logic res_d;
  logic cmd_sleep_d;
  logic cmd_shut_d;

  // a wake pulse counts on its rising (release) edge so a held pin
  // cannot cause repeated resets
  wire wake_pulse = pmc_rise(!wake_low, !wake_low_d);
  wire tone_pulse = pmc_rise(tone_lvl, tone_d);
  wire resume_lvl = res_uart | res_tone;
  wire resume_pulse = pmc_rise(resume_lvl, res_d);
  wire wake_event = wake_pulse | tone_pulse;
  // commands act on their rising edge: a bit left set cannot re-trigger
  wire sleep_req = pmc_rise(cmd.enter_sleep_cmd, cmd_sleep_d);
  wire shut_req = pmc_rise(cmd.enter_shutdown_cmd, cmd_shut_d);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_low_d <= 1'b0;
      tone_d <= 1'b0;
      res_d <= 1'b0;
      cmd_sleep_d <= 1'b0;
      cmd_shut_d <= 1'b0;
    end else begin
      wake_low_d <= wake_low;
      tone_d <= tone_lvl;
      res_d <= resume_lvl;
      cmd_sleep_d <= cmd.enter_sleep_cmd;
      cmd_shut_d <= cmd.enter_shutdown_cmd;
    end
  end

  // ------------------------------------------------------------
  // long communication timeout
  // ------------------------------------------------------------
  localparam logic [PMC_TO_WIDTH-1:0] TO_LAST =
    PMC_TO_WIDTH'(LONG_TO_CYCLES - 1);

  logic [PMC_TO_WIDTH-1:0] to_count;
  logic [PMC_TO_WIDTH-1:0] next_to_count;
  wire to_armed = (mode == PMC_ACTIVE) && cmd.long_timeout_enable;
  wire to_expired = to_armed && (to_count == TO_LAST) && !frame;

  // the count saturates so a long silence cannot wrap and re-arm
  assign next_to_count = (!to_armed || frame) ? '0 :
    (to_count == TO_LAST) ? to_count : to_count + 1'b1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      to_count <= '0;
    end else begin
      to_count <= next_to_count;
    end
  end

  // ------------------------------------------------------------
  // mode state machine
  // ------------------------------------------------------------
  pmc_mode_type next_mode;
  logic wake_reset;

  always_comb begin
    next_mode = mode;
    wake_reset = 1'b0;
    // supply loss beats every other cause, whatever the mode
    if (!ref_ok) begin
      next_mode = PMC_POR;
    end else begin
      unique case (mode)
        PMC_POR: begin
          next_mode = PMC_SHUTDOWN;
        end
        PMC_SHUTDOWN: begin
          if (wake_event) begin
            next_mode = PMC_ACTIVE;
            wake_reset = 1'b1;
          end
        end
        PMC_SLEEP: begin
          if (thermal) begin
            next_mode = PMC_SHUTDOWN;
          end else if (wake_event) begin
            next_mode = PMC_ACTIVE;
            wake_reset = 1'b1;
          end else if (resume_pulse) begin
            next_mode = PMC_ACTIVE;
          end
        end
        PMC_ACTIVE: begin
          if (thermal) begin
            next_mode = PMC_SHUTDOWN;
          end else if (shut_req || to_expired) begin
            next_mode = PMC_SHUTDOWN;
          end else if (sleep_req) begin
            next_mode = PMC_SLEEP;
          end else if (wake_event) begin
            wake_reset = 1'b1;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // reset-occurred flag and fault output
  // ------------------------------------------------------------
  // a new reset cause wins over a clear in the same cycle
  wire flag_set = (mode == PMC_POR && ref_ok) || wake_reset;
  wire next_flag = flag_set |
    (reset_occurred_flag & ~cmd.reset_flag_clear_bit);

  // ------------------------------------------------------------
  // next values of the registered outputs
  // ------------------------------------------------------------
  // enables, fault, heartbeat, settings and hold outputs come from the next mode so they
  // change on the same edge as the mode register; abort and forward pulses use the present mode
  wire is_active_next = (next_mode == PMC_ACTIVE);
  wire is_por_next = (next_mode == PMC_POR);
  wire in_active = (mode == PMC_ACTIVE);

  pmc_func_type next_func_enable;
  assign next_func_enable = pmc_gate(next_mode);

  // thermal trip drops straight to shutdown silently, so the fault
  // pin is never pulled low on its way out
  wire next_fault_output_n =
    !(next_flag && is_active_next) || thermal;
  // the heartbeat waits until the host has seen and cleared the flag
  wire next_heartbeat_run = !next_flag && is_active_next &&
    cmd.heartbeat_enable;
  // settings stay at default for as long as the supply is low
  wire next_settings_reset = wake_reset || is_por_next;
  // only an active device passes wake and resume on up the chain
  wire next_wake_forward = wake_reset && in_active;
  wire next_resume_forward = resume_pulse && in_active;
  wire next_abort_transactions =
    thermal && (mode != PMC_POR);
  wire next_circuits_held = is_por_next;

  // ------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= PMC_POR;
    end else begin
      mode <= next_mode;
    end
  end

  // the flag has its own register so a clear never disturbs the mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_occurred_flag <= PMC_FLAG_RESET;
    end else begin
      reset_occurred_flag <= next_flag;
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      func_enable <= '0;
      fault_output_n <= 1'b1;
      heartbeat_run <= 1'b0;
      abort_transactions <= 1'b0;
      circuits_held <= 1'b1;
    end else begin
      func_enable <= next_func_enable;
      fault_output_n <= next_fault_output_n;
      heartbeat_run <= next_heartbeat_run;
      abort_transactions <= next_abort_transactions;
      circuits_held <= next_circuits_held;
    end
  end

  // ------------------------------------------------------------
  // one-cycle pulses towards the settings and the chain; settings reset held through power-on reset
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settings_reset <= 1'b0;
      wake_forward <= 1'b0;
      resume_forward <= 1'b0;
    end else begin
      settings_reset <= next_settings_reset;
      wake_forward <= next_wake_forward;
      resume_forward <= next_resume_forward;
    end
  end

endmodule

/* tb/pmc_props.sv */
`timescale 1ns/100ps
module pmc_props
  import pmc_pkg::*;
#(
  parameter int LONG_TO_CYCLES = PMC_LONG_TO_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic always_on_reference,
  input wire logic wake_n,
  input wire logic wake_tone,
  input wire logic resume_uart,
  input wire logic resume_tone,
  input wire logic thermal_trip,
  input wire logic frame_valid,
  input wire pmc_cmd_type cmd,
  input wire pmc_mode_type mode,
  input wire pmc_func_type func_enable,
  input wire logic reset_occurred_flag,
  input wire logic fault_output_n,
  input wire logic heartbeat_run,
  input wire logic settings_reset,
  input wire logic wake_forward,
  input wire logic resume_forward,
  input wire logic abort_transactions,
  input wire logic circuits_held
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  por_hold_a: assert property (
    mode == PMC_POR |-> circuits_held && func_enable == '0)
    else $error("power-on reset not holding circuits");
  por_flag_a: assert property (
    mode == PMC_POR ##1 mode == PMC_SHUTDOWN |-> reset_occurred_flag)
    else $error("reset flag missing after power-on");
  gate_mode_a: assert property (
    func_enable.comms == (mode == PMC_ACTIVE) && func_enable.comparators
    == (mode inside {PMC_SLEEP, PMC_ACTIVE}))
    else $error("function enables disagree with mode");
  shut_cmd_a: assert property (
    mode == PMC_ACTIVE && always_on_reference &&
    $rose(cmd.enter_shutdown_cmd) |=> mode == PMC_SHUTDOWN)
    else $error("shutdown command ignored");
  shut_exit_a: assert property (
    mode == PMC_SHUTDOWN |=> mode != PMC_SLEEP)
    else $error("shutdown left for sleep");
  thermal_trip_a: assert property (
    (thermal_trip && always_on_reference)[*6] |->
    mode == PMC_SHUTDOWN && abort_transactions)
    else $error("thermal trip not handled");
  fault_pin_a: assert property (
    !fault_output_n || heartbeat_run |->
    mode == PMC_ACTIVE && (reset_occurred_flag ^ heartbeat_run))
    else $error("fault output or heartbeat wrong");
  wake_fwd_a: assert property (
    wake_forward |-> settings_reset && mode == PMC_ACTIVE
    ##[0:1] reset_occurred_flag)
    else $error("active wake not resetting");
  resume_fwd_a: assert property (
    resume_forward |-> mode == PMC_ACTIVE ##1 mode == PMC_ACTIVE)
    else $error("active resume changed mode");
endmodule

bind power_mode_controller pmc_props #(
  .LONG_TO_CYCLES(LONG_TO_CYCLES)
) u_props (.*);

/* tb/pmc_host_model.sv */
`timescale 1ns/100ps
module pmc_host_model (
  input wire logic core_clk,
  input wire logic talk,
  input wire logic wake_req,
  output logic frame_valid,
  output logic wake_n
);
  logic [2:0] gap;
  initial begin
    frame_valid = 1'b0;
    wake_n = 1'b1;
    gap = 3'h0;
  end
  // a frame every eight cycles, well inside the long timeout
  always @(negedge core_clk) begin
    gap <= gap + 3'h1;
    frame_valid <= talk && (gap == 3'h0);
  end
  // wake pulse: pin held low for six cycles, then released
  always @(posedge wake_req) begin
    wake_n <= 1'b0;
    repeat (6) @(negedge core_clk);
    wake_n <= 1'b1;
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
module testbench
  import pmc_pkg::*;
;
  logic core_clk = 1'b0, reset_n = 1'b0, ref_ok = 1'b0;
  logic wake_n, frame_valid, talk = 1'b0, wake_req = 1'b0;
  logic w_tone = 1'b0, r_uart = 1'b0, r_tone = 1'b0, therm = 1'b0;
  logic fault_n, flag, hb, held, abort;
  logic s_reset, w_fwd, r_fwd;
  int n_sreset = 0, n_wfwd = 0, n_rfwd = 0;
  pmc_cmd_type cmd = '0;
  pmc_mode_type mode;
  pmc_func_type fe;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  always #20 core_clk = ~core_clk;
  pmc_host_model host (.core_clk(core_clk), .talk(talk),
    .wake_req(wake_req), .frame_valid(frame_valid), .wake_n(wake_n));
  power_mode_controller #(.LONG_TO_CYCLES(20)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .always_on_reference(ref_ok),
    .wake_n(wake_n), .wake_tone(w_tone), .resume_uart(r_uart),
    .resume_tone(r_tone), .thermal_trip(therm), .frame_valid(frame_valid),
    .cmd(cmd), .mode(mode), .func_enable(fe), .reset_occurred_flag(flag),
    .fault_output_n(fault_n), .heartbeat_run(hb), .settings_reset(s_reset),
    .wake_forward(w_fwd), .resume_forward(r_fwd), .abort_transactions(abort),
    .circuits_held(held));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ceiling: the sequence needs well under 1000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // pulses stand one cycle, so a falling edge sees each of them once;
  // settings held at default through power-on reset are not counted
  always @(negedge core_clk) begin
    n_sreset += int'(s_reset === 1'b1 && mode != PMC_POR);
    n_wfwd += int'(w_fwd === 1'b1);
    n_rfwd += int'(r_fwd === 1'b1);
  end
  task automatic chk_count(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input pmc_mode_type exp);
    n_compared++;
    if (mode !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, mode, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // command bits act on a rising edge, so each pulse returns low
  task automatic pulse_cmd(input int b);
    cmd[b] = 1'b1;
    tick(1);
    cmd[b] = 1'b0;
    tick(4);
  endtask
  task automatic wake();
    wake_req = 1'b1;
    tick(1);
    wake_req = 1'b0;
    tick(14);
  endtask
  // 0 wake tone, 1 resume on uart, 2 resume tone
  task automatic event_in(input int k);
    {r_tone, r_uart, w_tone} = 3'h1 << k;
    tick(2);
    {r_tone, r_uart, w_tone} = 3'h0;
    tick(6);
  endtask
  task automatic clear_flag();
    cmd.reset_flag_clear_bit = 1'b1;
    tick(3);
    cmd.reset_flag_clear_bit = 1'b0;
  endtask
  initial begin
    cmd.heartbeat_enable = 1'b1;
    tick(20);
    reset_n = 1'b1;
    tick(5);
    chk_mode(PMC_POR);
    chk_bit(held, 1'b1);
    ref_ok = 1'b1;
    tick(6);
    chk_mode(PMC_SHUTDOWN);
    chk_bit(flag, 1'b1);
    pulse_cmd(4);
    event_in(1);
    chk_mode(PMC_SHUTDOWN);
    chk_bit(fe.comparators, 1'b0);
    wake();
    chk_mode(PMC_ACTIVE);
    chk_bit(fault_n, 1'b0);
    clear_flag();
    chk_bit(flag, 1'b0);
    chk_bit(fault_n, 1'b1);
    chk_bit(hb, 1'b1);
    event_in(2);
    chk_mode(PMC_ACTIVE);
    chk_bit(flag, 1'b0);
    pulse_cmd(4);
    chk_mode(PMC_SLEEP);
    chk_bit(fe.comparators & ~fe.comms, 1'b1);
    event_in(1);
    chk_mode(PMC_ACTIVE);
    chk_bit(flag, 1'b0);
    pulse_cmd(4);
    event_in(0);
    chk_mode(PMC_ACTIVE);
    chk_bit(flag, 1'b1);
    clear_flag();
    event_in(0);
    chk_bit(flag, 1'b1);
    cmd.enter_sleep_cmd = 1'b1;
    cmd.enter_shutdown_cmd = 1'b1;
    tick(1);
    cmd.enter_sleep_cmd = 1'b0;
    cmd.enter_shutdown_cmd = 1'b0;
    tick(2);
    chk_mode(PMC_SHUTDOWN);
    wake();
    therm = 1'b1;
    tick(5);
    chk_mode(PMC_SHUTDOWN);
    chk_bit(abort, 1'b1);
    therm = 1'b0;
    tick(20);
    chk_mode(PMC_SHUTDOWN);
    wake();
    cmd.long_timeout_enable = 1'b1;
    talk = 1'b1;
    tick(60);
    chk_mode(PMC_ACTIVE);
    talk = 1'b0;
    tick(30);
    chk_mode(PMC_SHUTDOWN);
    chk_count(n_sreset, 5);
    chk_count(n_wfwd, 1);
    chk_count(n_rfwd, 1);
    ref_ok = 1'b0;
    tick(5);
    chk_mode(PMC_POR);
    close_out();
  end
endmodule
